// >>> hw/dcr_core.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [dcr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dcr_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dcr_pkg::REG_W-1:0] reg_rdata,
    input wire logic [1:0] mode_strap,
    input wire logic pin4,
    input wire logic pin5,
    input wire logic pin6,
    output logic register_select,
    output logic read_not_write,
    output logic enable_strobe,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic serial_frame_strobe,
    output logic serial_clock,
    output var dcr_pkg::dcr_mode_t host_mode,
    output logic display_on,
    output logic cursor_on,
    output logic blink_on,
    output logic bus_width_select,
    output logic two_lines,
    output logic [1:0] luminance_level,
    output logic lum_on,
    output logic [dcr_pkg::AC_W-1:0] address_counter,
    output logic [dcr_pkg::AC_W-1:0] shift_offset,
    output logic init_done
);
    import dcr_pkg::*;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic strap_caught_q;
    dcr_mode_t mode_q;

    // Reset is asserted at once and released two edges later.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Straps and host pins come from outside and pass two flops. They carry
    // no reset, so the strap has reached the second flop before release.
    always_ff @(posedge clk) begin
        pin_s1_q <= {mode_strap, pin6, pin5, pin4};
        pin_s2_q <= pin_s1_q;
    end

    // The strap is caught once, at the first edge after release, from the
    // settled synchronised copy. Until then the shipped mode holds.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_caught_q <= 1'b0;
            mode_q <= MODE_M68;
        end else if (!strap_caught_q) begin
            strap_caught_q <= 1'b1;
            case (pin_s2_q[4:3])
                STRAP_I80: mode_q <= MODE_I80;
                STRAP_SER: mode_q <= MODE_SER;
                default: mode_q <= MODE_M68;
            endcase
        end
    end

    assign host_mode = mode_q;

    dcr_pin_mux u_mux (
        .mode(mode_q),
        .pin4(pin_s2_q[0]),
        .pin5(pin_s2_q[1]),
        .pin6(pin_s2_q[2]),
        .register_select(register_select),
        .read_not_write(read_not_write),
        .enable_strobe(enable_strobe),
        .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n),
        .serial_frame_strobe(serial_frame_strobe),
        .serial_clock(serial_clock)
    );

    // ------------------------------------------------------------
    // Power-up fill sequencer
    // ------------------------------------------------------------
    dcr_state_t state_q;
    logic [AC_W-1:0] fill_q;
    logic filling;

    assign filling = (state_q == ST_FILL);
    assign init_done = (state_q == ST_RUN);

    // One cell per cycle; the walk takes one edge per RAM location.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_FILL;
            fill_q <= AC_HOME;
        end else begin
            case (state_q)
                ST_FILL: begin
                    fill_q <= fill_q + 7'h01;
                    if (fill_q == AC_LAST) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_FILL;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_addr;
    logic wr_shift;
    logic wr_data;
    logic rd_data;

    // Accesses that move the counter are held off during the fill, so the
    // fill cannot race a host write; control bits stay writable.
    assign wr_ctrl = reg_wr && reg_addr == REG_CTRL;
    assign wr_addr = reg_wr && reg_addr == REG_ADDR && init_done;
    assign wr_shift = reg_wr && reg_addr == REG_SHIFT && init_done;
    assign wr_data = reg_wr && reg_addr == REG_DATA && init_done;
    assign rd_data = reg_rd && reg_addr == REG_DATA && init_done;

    // ------------------------------------------------------------
    // Mode bits
    // ------------------------------------------------------------
    logic inc_q;
    logic shw_q;

    // Entry, display and function bits start at their power-up values.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inc_q <= RST_INC;
            shw_q <= RST_SHW;
            display_on <= RST_DON;
            cursor_on <= RST_CUR;
            blink_on <= RST_BLK;
            bus_width_select <= RST_BW;
            two_lines <= RST_LN;
            luminance_level <= RST_LUM;
        end else if (wr_ctrl) begin
            inc_q <= reg_wdata[CTRL_INC];
            shw_q <= reg_wdata[CTRL_SHW];
            display_on <= reg_wdata[CTRL_DON];
            cursor_on <= reg_wdata[CTRL_CUR];
            blink_on <= reg_wdata[CTRL_BLK];
            bus_width_select <= reg_wdata[CTRL_BW];
            two_lines <= reg_wdata[CTRL_LN];
            luminance_level <= reg_wdata[CTRL_LUM +: 2];
        end
    end

    // ------------------------------------------------------------
    // Address counter and display shift
    // ------------------------------------------------------------
    logic [AC_W-1:0] step;

    assign step = inc_q ? 7'h01 : 7'h7F;

    // Data accesses step the counter; a write to the shift register homes it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            address_counter <= AC_HOME;
        end else if (wr_addr) begin
            address_counter <= reg_wdata[AC_W-1:0];
        end else if (wr_shift) begin
            address_counter <= AC_HOME;
        end else if (wr_data || rd_data) begin
            address_counter <= address_counter + step;
        end
    end

    // Only writes shift the picture, and only with shift-on-write set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_offset <= AC_HOME;
        end else if (wr_shift) begin
            shift_offset <= AC_HOME;
        end else if (wr_data && shw_q) begin
            shift_offset <= shift_offset + step;
        end
    end

    // ------------------------------------------------------------
    // Display memory
    // ------------------------------------------------------------
    logic ram_we;
    logic [AC_W-1:0] ram_waddr;
    logic [DATA_W-1:0] ram_wdata;
    logic [DATA_W-1:0] ram_rdata;

    assign ram_we = filling || wr_data;
    assign ram_waddr = filling ? fill_q : address_counter;
    assign ram_wdata = filling ? SPACE_CODE : reg_wdata[DATA_W-1:0];

    dcr_ram u_ram (
        .clk(clk),
        .we(ram_we),
        .waddr(ram_waddr),
        .wdata(ram_wdata),
        .raddr(address_counter),
        .rdata(ram_rdata)
    );

    // ------------------------------------------------------------
    // Luminance duty
    // ------------------------------------------------------------
    logic [15:0] div_q;
    logic step_en;
    logic [1:0] phase_q;

    assign step_en = (div_q == LUM_STEP_CYC - 16'h0001);

    // Divider giving one enable pulse per duty step.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= step_en ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // Four-step frame; the level code blanks that many trailing steps.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            lum_on <= 1'b0;
        end else begin
            if (step_en) begin
                phase_q <= phase_q + 2'h1;
            end
            lum_on <= display_on && (phase_q <= ~luminance_level);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic rd_data_q;
    logic [REG_W-1:0] rdata_q;

    // Read data stand only in the cycle after the strobe; unmapped
    // addresses read zero. Data reads come straight from the memory flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            rd_data_q <= reg_rd && reg_addr == REG_DATA;
            rdata_q <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    REG_CTRL: rdata_q <= {6'h00, luminance_level, 1'b0,
                        two_lines, bus_width_select, blink_on, cursor_on,
                        display_on, shw_q, inc_q};
                    REG_ADDR: rdata_q <= {8'h00, 1'b0, address_counter};
                    REG_SHIFT: rdata_q <= {9'h000, shift_offset};
                    REG_STATUS: rdata_q <= {12'h000, init_done, mode_q};
                    default: rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    assign reg_rdata = rd_data_q ? {8'h00, ram_rdata} : rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fill_space: assert property (@(posedge clk) disable iff (!rst_n)
        filling |-> ram_we && ram_wdata == SPACE_CODE && ram_waddr == fill_q)
        else $error("Fill writes something other than a space.");

    a_fill_end: assert property (@(posedge clk) disable iff (!rst_n)
        filling && fill_q == AC_LAST |=> init_done ##1 init_done)
        else $error("Fill does not end after the last cell.");

    a_ac_home: assert property (@(posedge clk) disable iff (!rst_n)
        !init_done |-> address_counter == AC_HOME)
        else $error("Address counter not home during fill.");

    a_shift_clear: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(init_done) |-> shift_offset == AC_HOME)
        else $error("Shift offset not clear after fill.");

    a_entry_dflt: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(init_done) && !$past(wr_ctrl, 1) |-> inc_q && !shw_q)
        else $error("Entry bits wrong after reset.");

    a_disp_dflt: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(init_done) && !$past(wr_ctrl, 1) |->
        !display_on && !cursor_on && !blink_on && !lum_on)
        else $error("Display bits wrong after reset.");

    a_func_dflt: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(init_done) && !$past(wr_ctrl, 1) |->
        bus_width_select && two_lines && luminance_level == 2'h0)
        else $error("Function bits wrong after reset.");

    a_mode_dflt: assert property (@(posedge clk) disable iff (!rst_n)
        strap_caught_q && $past(pin_s2_q[4:3], 1) == 2'h0 && !$past(strap_caught_q, 1)
        |-> mode_q == MODE_M68)
        else $error("Default strap did not select the strobed mode.");

    a_ac_read: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == REG_ADDR |=>
        reg_rdata == {9'h000, $past(address_counter, 1)})
        else $error("Counter read shows wrong value or busy set.");

    a_lum_quarter: assert property (@(posedge clk) disable iff (!rst_n)
        luminance_level == 2'h3 && $past(luminance_level, 1) == 2'h3 &&
        $past(phase_q, 1) != 2'h0 |-> !lum_on)
        else $error("Quarter brightness lit outside its step.");

    a_serial_pins: assert property (@(posedge clk) disable iff (!rst_n)
        mode_q == MODE_SER |-> serial_clock == pin_s2_q[2] &&
        serial_frame_strobe == pin_s2_q[0] && !enable_strobe)
        else $error("Serial roles not on shared pins.");
endmodule : dcr_core
`default_nettype wire

// >>> hw/dcr_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_pin_mux (
    input wire dcr_pkg::dcr_mode_t mode,
    input wire logic pin4,
    input wire logic pin5,
    input wire logic pin6,
    output logic register_select,
    output logic read_not_write,
    output logic enable_strobe,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic serial_frame_strobe,
    output logic serial_clock
);
    import dcr_pkg::*;

    // Pin 4 is register select or the serial strobe; pin 6 is the enable,
    // the read strobe or the serial clock. Unused roles sit idle.
    always_comb begin
        register_select = 1'b0;
        read_not_write = 1'b1;
        enable_strobe = 1'b0;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        serial_frame_strobe = 1'b1;
        serial_clock = 1'b1;
        case (mode)
            MODE_M68: begin
                register_select = pin4;
                read_not_write = pin5;
                enable_strobe = pin6;
            end
            MODE_I80: begin
                register_select = pin4;
                write_strobe_n = pin5;
                read_strobe_n = pin6;
            end
            MODE_SER: begin
                serial_frame_strobe = pin4;
                serial_clock = pin6;
            end
            default: begin
                register_select = pin4;
            end
        endcase
    end
endmodule : dcr_pin_mux
`default_nettype wire

// >>> hw/dcr_pkg.sv
package dcr_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int AC_W = 7;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int REG_W = 16;
    localparam int RAM_DEPTH = 128;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_ADDR = 5'h04;
    localparam logic [ADDR_W-1:0] REG_SHIFT = 5'h08;
    localparam logic [ADDR_W-1:0] REG_DATA = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;

    // ------------------------------------------------------------
    // Control field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_INC = 0;
    localparam int CTRL_SHW = 1;
    localparam int CTRL_DON = 2;
    localparam int CTRL_CUR = 3;
    localparam int CTRL_BLK = 4;
    localparam int CTRL_BW = 5;
    localparam int CTRL_LN = 6;
    localparam int CTRL_LUM = 8;
    localparam int STAT_DONE = 3;
    localparam int ADDR_BUSY = 7;
    localparam logic RST_INC = 1'b1;
    localparam logic RST_SHW = 1'b0;
    localparam logic RST_DON = 1'b0;
    localparam logic RST_CUR = 1'b0;
    localparam logic RST_BLK = 1'b0;
    localparam logic RST_BW = 1'b1;
    localparam logic RST_LN = 1'b1;
    localparam logic [1:0] RST_LUM = 2'h0;
    localparam logic [DATA_W-1:0] SPACE_CODE = 8'h20;
    localparam logic [AC_W-1:0] AC_HOME = 7'h00;
    localparam logic [AC_W-1:0] AC_LAST = 7'h7F;

    // ------------------------------------------------------------
    // Modes, straps, states and timing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_M68 = 3'b001,
        MODE_I80 = 3'b010,
        MODE_SER = 3'b100
    } dcr_mode_t;
    localparam logic [1:0] STRAP_I80 = 2'h1;
    localparam logic [1:0] STRAP_SER = 2'h2;
    typedef enum logic [1:0] {
        ST_FILL = 2'b01,
        ST_RUN = 2'b10
    } dcr_state_t;
    localparam logic [15:0] LUM_STEP_CYC = 16'h0014;
endpackage : dcr_pkg

// >>> hw/dcr_ram.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_ram (
    input wire logic clk,
    input wire logic we,
    input wire logic [dcr_pkg::AC_W-1:0] waddr,
    input wire logic [dcr_pkg::DATA_W-1:0] wdata,
    input wire logic [dcr_pkg::AC_W-1:0] raddr,
    output logic [dcr_pkg::DATA_W-1:0] rdata
);
    import dcr_pkg::*;

    logic [DATA_W-1:0] mem [RAM_DEPTH];

    // Storage has no reset; the fill sequencer writes every cell instead.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data always come out of a register, one cycle after the address.
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : dcr_ram
`default_nettype wire

// >>> sim/dcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host processor pin driver
// ------------------------------------------------------------
module dcr_host_model (
    input wire logic clk,
    input wire logic [2:0] drive_val,
    output logic pin4,
    output logic pin5,
    output logic pin6
);
    // Start from idle strobe levels so the shared pins are never unknown.
    initial begin
        pin4 = 1'b0;
        pin5 = 1'b1;
        pin6 = 1'b1;
    end

    // Pins move just after an edge, like a real host, so setup is never marginal.
    always @(posedge clk) begin
        pin4 <= drive_val[0];
        pin5 <= drive_val[1];
        pin6 <= drive_val[2];
    end
endmodule : dcr_host_model
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dcr_pkg::*;
    // ------------------------------------------------------------
    // Signals and design hookup
    // ------------------------------------------------------------
    logic clk, nrst, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [REG_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic [1:0] mode_strap, luminance_level;
    logic [2:0] host_val;
    logic pin4, pin5, pin6, register_select, read_not_write, enable_strobe;
    logic write_strobe_n, read_strobe_n, serial_frame_strobe, serial_clock;
    logic display_on, cursor_on, blink_on, bus_width_select, two_lines, lum_on, init_done;
    logic [AC_W-1:0] address_counter, shift_offset, a;
    logic [7:0] d;
    logic [31:0] v;
    dcr_mode_t host_mode;
    int mismatches, samples_checked, i, m, n;
    integer seed;

    dcr_core dut_u (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_strap(mode_strap),
        .pin4(pin4), .pin5(pin5), .pin6(pin6), .register_select(register_select),
        .read_not_write(read_not_write), .enable_strobe(enable_strobe),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .serial_frame_strobe(serial_frame_strobe), .serial_clock(serial_clock),
        .host_mode(host_mode), .display_on(display_on), .cursor_on(cursor_on),
        .blink_on(blink_on), .bus_width_select(bus_width_select), .two_lines(two_lines),
        .luminance_level(luminance_level), .lum_on(lum_on),
        .address_counter(address_counter), .shift_offset(shift_offset),
        .init_done(init_done)
    );

    dcr_host_model host_u (.clk(clk), .drive_val(host_val), .pin4(pin4), .pin5(pin5), .pin6(pin6));

    // A free-running 20 MHz clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] ctrl_word(logic inc, logic shw, logic don, logic cur,
                                              logic blk, logic bw, logic ln, logic [1:0] lum);
        logic [15:0] w;
        w = 16'h0000;
        w[CTRL_INC] = inc;
        w[CTRL_SHW] = shw;
        w[CTRL_DON] = don;
        w[CTRL_CUR] = cur;
        w[CTRL_BLK] = blk;
        w[CTRL_BW] = bw;
        w[CTRL_LN] = ln;
        w[CTRL_LUM+:2] = lum;
        return w;
    endfunction : ctrl_word

    // Strap codes other than the two alternatives fall back to the shipped mode.
    function automatic dcr_mode_t mode_of(logic [1:0] st);
        if (st == STRAP_I80) return MODE_I80;
        if (st == STRAP_SER) return MODE_SER;
        return MODE_M68;
    endfunction : mode_of

    // Order: select, rw, enable, wr_n, rd_n, frame strobe, serial clock.
    function automatic logic [6:0] mux_exp(dcr_mode_t md, logic [2:0] p);
        if (md == MODE_I80) return {p[0], 1'b1, 1'b0, p[1], p[2], 1'b1, 1'b1};
        if (md == MODE_SER) return {1'b0, 1'b1, 1'b0, 1'b1, 1'b1, p[0], p[2]};
        return {p[0], p[1], p[2], 1'b1, 1'b1, 1'b1, 1'b1};
    endfunction : mux_exp

    // Full brightness keeps the segment on all frame, each step down drops a quarter.
    function automatic logic [15:0] lum_exp(logic [1:0] lvl);
        return 16'((4 - int'(lvl)) * int'(LUM_STEP_CYC));
    endfunction : lum_exp

    // ------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [ADDR_W-1:0] ad, input logic [15:0] wd);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // Data stands only in the cycle after the strobe, so sample just past that edge.
    task automatic reg_read(input logic [ADDR_W-1:0] ad, output logic [15:0] rd);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask : reg_read

    task automatic do_reset(input logic [1:0] st);
        int k;
        @(posedge clk);
        mode_strap <= st;
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check({9'h0, luminance_level, two_lines, bus_width_select, blink_on, cursor_on,
               display_on}, 16'h0018, "reset controls");
        check({address_counter, shift_offset, init_done, lum_on}, 16'h0000, "reset state");
        nrst = 1'b1;
        k = 0;
        while (init_done !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        check({15'h0, init_done}, 16'h0001, "fill finished");
    endtask : do_reset

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // A hang is cut short long after the sequence should have ended.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("BAD at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hf820;
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        mode_strap = 2'h0;
        host_val = 3'h3;
        mismatches = 0;
        samples_checked = 0;
        // Every strap code, then random host pin traffic through the mux.
        for (m = 0; m < 4; m++) begin
            do_reset(2'(m));
            check({13'h0, host_mode}, {13'h0, mode_of(2'(m))}, "host mode");
            reg_read(REG_STATUS, rd_val);
            check(rd_val, {12'h0, 1'b1, mode_of(2'(m))}, "status");
            repeat (6) begin
                @(posedge clk);
                v = $random(seed);
                host_val <= v[2:0];
                repeat (4) @(posedge clk);
                #1;
                check({9'h0, register_select, read_not_write, enable_strobe, write_strobe_n,
                       read_strobe_n, serial_frame_strobe, serial_clock},
                      {9'h0, mux_exp(mode_of(2'(m)), host_val)}, "pin mux");
            end
        end
        // Random writes with readback; the first one wraps the counter at the top.
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            a = (i == 0) ? 7'h7F : v[6:0];
            d = v[15:8];
            reg_write(REG_ADDR, {9'h0, a});
            reg_write(REG_DATA, {8'h0, d});
            check({9'h0, address_counter}, {9'h0, a + 7'h1}, "counter step");
            check({9'h0, shift_offset}, 16'h0000, "no shift on write");
            reg_write(REG_ADDR, {9'h0, a});
            reg_read(REG_DATA, rd_val);
            check(rd_val, {8'h0, d}, "readback");
        end
        // Shift on write moves the offset; a shift write puts everything home.
        reg_write(REG_CTRL, ctrl_word(1, 1, 0, 0, 0, 1, 1, 2'h0));
        reg_write(REG_DATA, 16'h0041);
        check({9'h0, shift_offset}, 16'h0001, "offset shifted");
        reg_write(REG_SHIFT, 16'h0000);
        check({address_counter, shift_offset, 2'b00}, 16'h0000, "shift cleared");
        // Each luminance code gives its own on-time over one full dimming frame.
        for (m = 0; m < 4; m++) begin
            reg_write(REG_CTRL, ctrl_word(1, 0, 1, 1, 1, 1, 1, 2'(m)));
            check({11'h0, luminance_level, display_on, cursor_on, blink_on},
                  {11'h0, 2'(m), 3'b111}, "display controls");
            repeat (8) @(posedge clk);
            n = 0;
            repeat (4 * int'(LUM_STEP_CYC)) begin
                @(posedge clk);
                #1;
                if (lum_on === 1'b1) n++;
            end
            check(16'(n), lum_exp(2'(m)), "luminance duty");
        end
        // A reset in mid-run must bring back every default and a fresh fill.
        do_reset(2'h0);
        reg_read(REG_CTRL, rd_val);
        check(rd_val, ctrl_word(1, 0, 0, 0, 0, 1, 1, 2'h0), "control defaults");
        reg_read(REG_ADDR, rd_val);
        check(rd_val, 16'h0000, "counter read");
        reg_read(5'h14, rd_val);
        check(rd_val, 16'h0000, "unmapped read");
        for (i = 0; i < RAM_DEPTH; i++) begin
            reg_read(REG_DATA, rd_val);
            check(rd_val, 16'h0020, "space fill");
            check({9'h0, address_counter}, {9'h0, 7'(i + 1)}, "read step");
        end
        reg_write(REG_ADDR, 16'h0005);
        reg_read(REG_ADDR, rd_val);
        check(rd_val, 16'h0005, "counter read busy low");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
